// file: inc/blit_pkg.sv
package blit_pkg;

    // -------------------------------------------------------------
    // Geometry and capacity
    // -------------------------------------------------------------
    localparam int unsigned NUM_FONTS  = 2;
    localparam int unsigned FONT_CHARS = 4096;
    localparam int unsigned MAX_WIDTH  = 63;
    localparam int unsigned MAX_HEIGHT = 60;
    localparam int unsigned NUM_PLANES = 4;
    localparam int unsigned WORD_BITS  = 16;
    localparam int unsigned COORD_BITS = 12;
    localparam int unsigned MADDR_BITS = 24;

    // -------------------------------------------------------------
    // Register offsets (byte addresses)
    // -------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_PEN_X  = 8'h08;
    localparam logic [7:0] OFS_PEN_Y  = 8'h0C;
    localparam logic [7:0] OFS_RETURN = 8'h10;
    localparam logic [7:0] OFS_FONT0  = 8'h14;
    localparam logic [7:0] OFS_FONT1  = 8'h18;
    localparam logic [7:0] OFS_LIST   = 8'h1C;

    // -------------------------------------------------------------
    // Field layouts
    // -------------------------------------------------------------
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_CFG_LSB   = 1;
    localparam int unsigned TERM_BIT       = 3;

    typedef struct packed {
        logic [1:0] font_plane;
        logic [3:0] activity;
        logic [2:0] combine_op;
        logic       invert;
        logic       single_plane;
        logic       cell_scale;
    } ctrl_t;

    typedef struct packed {
        logic [1:0] direction;
        logic [3:0] extent;
        logic [3:0] skip;
        logic [5:0] advance;
    } attr_t;

    typedef struct packed {
        logic        cont;
        logic        font_sel;
        logic [11:0] index;
    } entry_t;

    typedef logic [NUM_PLANES-1:0][WORD_BITS-1:0] planes_t;

    // -------------------------------------------------------------
    // Reset values and encodings
    // -------------------------------------------------------------
    localparam ctrl_t CTRL_RESET = '{font_plane: 2'h0, activity: 4'hF, combine_op: 3'h3,
                                     invert: 1'b0, single_plane: 1'b0, cell_scale: 1'b0};
    localparam logic [COORD_BITS-1:0] PEN_RESET  = 12'h000;
    localparam logic [MADDR_BITS-1:0] FONT_RESET = 24'h000000;

    localparam logic [1:0] RET_NONE = 2'h0;
    localparam logic [1:0] RET_X    = 2'h1;
    localparam logic [1:0] RET_Y    = 2'h2;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_ENTRY = 8'h02,
        ST_PTR   = 8'h04,
        ST_ATTR  = 8'h08,
        ST_PAT   = 8'h10,
        ST_RDD   = 8'h20,
        ST_WRD   = 8'h40,
        ST_ADV   = 8'h80
    } state_t;

endpackage : blit_pkg

// file: verilog/string_blitter.sv
module string_blitter (
    input  wire logic                               clk_i,
    input  wire logic                               nrst_i,
    input  wire logic                               en_i,
    input  wire logic [7:0]                         reg_addr_i,
    input  wire logic [31:0]                        reg_wdata_i,
    input  wire logic                               reg_wr_i,
    input  wire logic                               reg_rd_i,
    output logic      [31:0]                        reg_rdata_o,
    output logic                                    mem_req_o,
    output logic                                    mem_we_o,
    output logic                                    mem_pixel_o,
    output logic      [blit_pkg::MADDR_BITS-1:0]    mem_addr_o,
    output blit_pkg::planes_t                       mem_wdata_o,
    output logic      [blit_pkg::WORD_BITS-1:0]     mem_wmask_o,
    output logic      [blit_pkg::NUM_PLANES-1:0]    mem_plane_we_o,
    input  wire logic                               mem_ack_i,
    input  wire blit_pkg::planes_t                  mem_rdata_i
);

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    blit_pkg::state_t                       state_q, state_d;
    blit_pkg::ctrl_t                        cfg_q, cfg_d;
    blit_pkg::attr_t                        attr_q, attr_d;
    blit_pkg::entry_t                       entry_q, entry_d, cur_q, cur_d;
    blit_pkg::planes_t                      pat_q, pat_d, wdata_q, wdata_d;
    logic [blit_pkg::NUM_PLANES-1:0]        plane_we_q, plane_we_d;
    logic                                   entry_vld_q, entry_vld_d;
    logic [blit_pkg::COORD_BITS-1:0]        pen_x_q, pen_x_d, pen_y_q, pen_y_d, ret_q, ret_d;
    logic [blit_pkg::MADDR_BITS-1:0]        font0_q, font0_d, font1_q, font1_d;
    logic [blit_pkg::MADDR_BITS-1:0]        base_q, base_d, ptr_q, ptr_d, maddr_q, maddr_d;
    logic [5:0]                             row_q, row_d;
    logic [1:0]                             word_q, word_d;
    logic                                   req_q, req_d, we_q, we_d, pix_q, pix_d;
    logic [blit_pkg::WORD_BITS-1:0]         mask_q, mask_d;
    logic [31:0]                            rdata_q, rdata_d;

    // -------------------------------------------------------------
    // Geometry of the current character
    // -------------------------------------------------------------
    logic [5:0]                             lines_ext, lines_skip;
    logic [2:0]                             nwords;
    logic [6:0]                             rem_px;
    logic [4:0]                             valid_px;
    logic [blit_pkg::COORD_BITS-1:0]        x_start, dst_x, dst_y;
    logic [blit_pkg::WORD_BITS-1:0]         font_word;
    blit_pkg::planes_t                      comb_word;

    always_comb begin
        lines_ext  = cfg_q.cell_scale ? {attr_q.extent, 2'b00} : {1'b0, attr_q.extent, 1'b0};
        lines_skip = cfg_q.cell_scale ? {attr_q.skip, 2'b00} : {1'b0, attr_q.skip, 1'b0};
        nwords     = 3'((7'(attr_q.advance) + 7'd15) >> 4);
        rem_px     = 7'(attr_q.advance) - {1'b0, word_q, 4'h0};
        valid_px   = (rem_px >= 7'd16) ? 5'd16 : 5'(rem_px);
        x_start    = attr_q.direction[0] ? pen_x_q - 12'(attr_q.advance) : pen_x_q;
        dst_x      = x_start + {6'h00, word_q, 4'h0};
        dst_y      = pen_y_q + 12'(lines_skip) + 12'(row_q);
        font_word  = mem_rdata_i[cfg_q.font_plane];
    end

    // Combine source and destination per plane
    function automatic logic [15:0] combine(input logic [2:0] op, input logic [15:0] s, input logic [15:0] d);
        case (op)
            3'h0:    combine = 16'h0000;
            3'h1:    combine = s & d;
            3'h2:    combine = s & ~d;
            3'h3:    combine = s;
            3'h4:    combine = ~s & d;
            3'h5:    combine = d;
            3'h6:    combine = s ^ d;
            default: combine = s | d;
        endcase
    endfunction : combine

    genvar p;
    generate
        for (p = 0; p < blit_pkg::NUM_PLANES; p++) begin : g_plane
            logic [15:0] src;
            assign src = (cfg_q.single_plane ? pat_q[cfg_q.font_plane] : pat_q[p])
                         ^ {16{cfg_q.invert}};
            assign comb_word[p] = combine(cfg_q.combine_op, src, mem_rdata_i[p]);
        end
    endgenerate

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb begin
        state_d     = state_q;
        cfg_d       = cfg_q;
        attr_d      = attr_q;
        entry_d     = entry_q;
        entry_vld_d = entry_vld_q;
        cur_d       = cur_q;
        pat_d       = pat_q;
        wdata_d     = wdata_q;
        pen_x_d     = pen_x_q;
        pen_y_d     = pen_y_q;
        ret_d       = ret_q;
        font0_d     = font0_q;
        font1_d     = font1_q;
        base_d      = base_q;
        ptr_d       = ptr_q;
        maddr_d     = maddr_q;
        row_d       = row_q;
        word_d      = word_q;
        req_d       = req_q & ~mem_ack_i;
        we_d        = we_q;
        pix_d       = pix_q;
        mask_d      = mask_q;
        rdata_d     = 32'h0000_0000;

        if (reg_rd_i) begin
            case (reg_addr_i)
                blit_pkg::OFS_CTRL:   rdata_d = 32'({cfg_q, 1'b0});
                blit_pkg::OFS_STATUS: rdata_d = {29'h0, state_q == blit_pkg::ST_ENTRY, entry_vld_q,
                                                 state_q != blit_pkg::ST_IDLE};
                blit_pkg::OFS_PEN_X:  rdata_d = 32'(pen_x_q);
                blit_pkg::OFS_PEN_Y:  rdata_d = 32'(pen_y_q);
                blit_pkg::OFS_RETURN: rdata_d = 32'(ret_q);
                blit_pkg::OFS_FONT0:  rdata_d = 32'(font0_q);
                blit_pkg::OFS_FONT1:  rdata_d = 32'(font1_q);
                blit_pkg::OFS_LIST:   rdata_d = 32'(entry_q);
                default:              rdata_d = 32'h0000_0000;
            endcase
        end

        // Engine
        case (state_q)
            blit_pkg::ST_IDLE: begin
                row_d  = 6'd0;
                word_d = 2'd0;
            end
            blit_pkg::ST_ENTRY: begin
                if (entry_vld_q) begin
                    cur_d       = entry_q;
                    entry_vld_d = 1'b0;
                    base_d      = entry_q.font_sel ? font1_q : font0_q;
                    maddr_d     = (entry_q.font_sel ? font1_q : font0_q) + 24'(entry_q.index);
                    req_d       = 1'b1;
                    we_d        = 1'b0;
                    pix_d       = 1'b0;
                    state_d     = blit_pkg::ST_PTR;
                end
            end
            blit_pkg::ST_PTR: begin
                if (mem_ack_i) begin
                    maddr_d = base_q + 24'(font_word);
                    req_d   = 1'b1;
                    state_d = blit_pkg::ST_ATTR;
                end
            end
            blit_pkg::ST_ATTR: begin
                if (mem_ack_i) begin
                    attr_d = font_word;
                    ptr_d  = maddr_q + 24'd1;
                    row_d  = 6'd0;
                    word_d = 2'd0;
                    if (font_word[13:10] == 4'h0) begin
                        case (font_word[7:6])
                            blit_pkg::RET_X: pen_x_d = ret_q;
                            blit_pkg::RET_Y: pen_y_d = ret_q;
                            default:         pen_x_d = pen_x_q;
                        endcase
                        state_d = (font_word[6 + blit_pkg::TERM_BIT] || !cur_q.cont) ?
                                  blit_pkg::ST_IDLE : blit_pkg::ST_ENTRY;
                    end else if (font_word[5:0] == 6'd0) begin
                        state_d = blit_pkg::ST_ADV;
                    end else begin
                        maddr_d = maddr_q + 24'd1;
                        req_d   = 1'b1;
                        state_d = blit_pkg::ST_PAT;
                    end
                end
            end
            blit_pkg::ST_PAT: begin
                if (mem_ack_i) begin
                    pat_d   = mem_rdata_i;
                    ptr_d   = ptr_q + 24'd1;
                    maddr_d = {dst_y, dst_x};
                    pix_d   = 1'b1;
                    req_d   = 1'b1;
                    state_d = blit_pkg::ST_RDD;
                end
            end
            blit_pkg::ST_RDD: begin
                if (mem_ack_i) begin
                    wdata_d = comb_word;
                    we_d    = 1'b1;
                    req_d   = 1'b1;
                    mask_d  = ~(16'hFFFF >> valid_px);
                    state_d = blit_pkg::ST_WRD;
                end
            end
            blit_pkg::ST_WRD: begin
                if (mem_ack_i) begin
                    we_d    = 1'b0;
                    pix_d   = 1'b0;
                    maddr_d = ptr_q;
                    if (3'(word_q) + 3'd1 < nwords) begin
                        word_d  = word_q + 2'd1;
                        req_d   = 1'b1;
                        state_d = blit_pkg::ST_PAT;
                    end else if (row_q + 6'd1 < lines_ext) begin
                        word_d  = 2'd0;
                        row_d   = row_q + 6'd1;
                        req_d   = 1'b1;
                        state_d = blit_pkg::ST_PAT;
                    end else begin
                        state_d = blit_pkg::ST_ADV;
                    end
                end
            end
            blit_pkg::ST_ADV: begin
                pen_x_d = attr_q.direction[0] ? pen_x_q - 12'(attr_q.advance)
                                              : pen_x_q + 12'(attr_q.advance);
                state_d = cur_q.cont ? blit_pkg::ST_ENTRY : blit_pkg::ST_IDLE;
            end
            default: state_d = blit_pkg::ST_IDLE;
        endcase

        if (reg_wr_i) begin
            case (reg_addr_i)
                blit_pkg::OFS_CTRL: begin
                    if (state_q == blit_pkg::ST_IDLE) begin
                        cfg_d = reg_wdata_i[blit_pkg::CTRL_CFG_LSB +: $bits(blit_pkg::ctrl_t)];
                        if (reg_wdata_i[blit_pkg::CTRL_START_BIT]) begin
                            state_d = blit_pkg::ST_ENTRY;
                        end
                    end
                end
                blit_pkg::OFS_PEN_X:  if (state_q == blit_pkg::ST_IDLE) pen_x_d = reg_wdata_i[11:0];
                blit_pkg::OFS_PEN_Y:  if (state_q == blit_pkg::ST_IDLE) pen_y_d = reg_wdata_i[11:0];
                blit_pkg::OFS_RETURN: ret_d   = reg_wdata_i[11:0];
                blit_pkg::OFS_FONT0:  font0_d = reg_wdata_i[23:0];
                blit_pkg::OFS_FONT1:  font1_d = reg_wdata_i[23:0];
                blit_pkg::OFS_LIST: begin
                    entry_d     = reg_wdata_i[13:0];
                    entry_vld_d = 1'b1;
                end
                default: ;
            endcase
        end
        plane_we_d = we_d ? cfg_q.activity : 4'h0;
    end

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q     <= blit_pkg::ST_IDLE;
            cfg_q       <= blit_pkg::CTRL_RESET;
            attr_q      <= '0;
            entry_q     <= '0;
            entry_vld_q <= 1'b0;
            cur_q       <= '0;
            pat_q       <= '0;
            plane_we_q  <= 4'h0;
            wdata_q     <= '0;
            pen_x_q     <= blit_pkg::PEN_RESET;
            pen_y_q     <= blit_pkg::PEN_RESET;
            ret_q       <= blit_pkg::PEN_RESET;
            font0_q     <= blit_pkg::FONT_RESET;
            font1_q     <= blit_pkg::FONT_RESET;
            base_q      <= blit_pkg::FONT_RESET;
            ptr_q       <= blit_pkg::FONT_RESET;
            maddr_q     <= blit_pkg::FONT_RESET;
            row_q       <= 6'd0;
            word_q      <= 2'd0;
            req_q       <= 1'b0;
            we_q        <= 1'b0;
            pix_q       <= 1'b0;
            mask_q      <= 16'h0000;
            rdata_q     <= 32'h0000_0000;
        end else if (en_i) begin
            state_q     <= state_d;
            cfg_q       <= cfg_d;
            attr_q      <= attr_d;
            entry_q     <= entry_d;
            entry_vld_q <= entry_vld_d;
            cur_q       <= cur_d;
            pat_q       <= pat_d;
            plane_we_q  <= plane_we_d;
            wdata_q     <= wdata_d;
            pen_x_q     <= pen_x_d;
            pen_y_q     <= pen_y_d;
            ret_q       <= ret_d;
            font0_q     <= font0_d;
            font1_q     <= font1_d;
            base_q      <= base_d;
            ptr_q       <= ptr_d;
            maddr_q     <= maddr_d;
            row_q       <= row_d;
            word_q      <= word_d;
            req_q       <= req_d;
            we_q        <= we_d;
            pix_q       <= pix_d;
            mask_q      <= mask_d;
            rdata_q     <= rdata_d;
        end
    end

    assign reg_rdata_o    = rdata_q;
    assign mem_req_o      = req_q;
    assign mem_we_o       = we_q;
    assign mem_pixel_o    = pix_q;
    assign mem_addr_o     = maddr_q;
    assign mem_wdata_o    = wdata_q;
    assign mem_wmask_o    = mask_q;
    assign mem_plane_we_o = plane_we_q;

endmodule : string_blitter

// file: verification/string_blitter_checker.sv
module string_blitter_checker (
    input wire logic              clk_i,
    input wire logic              nrst_i,
    input wire logic              en_i,
    input wire logic              reg_rd_i,
    input wire logic [31:0]       reg_rdata_o,
    input wire logic              mem_req_o,
    input wire logic              mem_we_o,
    input wire logic              mem_pixel_o,
    input wire logic [23:0]       mem_addr_o,
    input wire blit_pkg::planes_t mem_wdata_o,
    input wire logic [15:0]       mem_wmask_o,
    input wire logic [3:0]        mem_plane_we_o,
    input wire logic              mem_ack_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    AST_REQ_HOLD: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
        else $error("memory request moved before acknowledge");
    AST_WR_DATA_HOLD: assert property (mem_req_o && mem_we_o && !mem_ack_i |=> $stable(mem_wdata_o) && $stable(mem_wmask_o))
        else $error("write data moved before acknowledge");
    AST_READ_NO_PLANE_WE: assert property (!mem_we_o |-> mem_plane_we_o == 4'h0)
        else $error("plane enables active on a read");
    AST_WR_PIXEL: assert property (mem_req_o && mem_we_o |-> mem_pixel_o)
        else $error("write not aimed at the pixel area");
    AST_WMASK_SHAPE: assert property (mem_req_o && mem_we_o |-> mem_wmask_o != 16'h0000 && ((~mem_wmask_o) & ((~mem_wmask_o) + 16'h0001)) == 16'h0000)
        else $error("write mask not a left aligned run");
    AST_RMW_SAME_ADDR: assert property (mem_req_o && mem_we_o && $past(mem_req_o) && !$past(mem_we_o) |-> $past(mem_pixel_o) && $past(mem_addr_o) == mem_addr_o)
        else $error("write not preceded by a read of the same word");
    AST_ACK_ADVANCES: assert property (mem_req_o && mem_ack_i |=> !mem_req_o || mem_we_o != $past(mem_we_o) || mem_pixel_o != $past(mem_pixel_o) || mem_addr_o != $past(mem_addr_o))
        else $error("access repeated after acknowledge");
    AST_RDATA_IDLE: assert property ($past(en_i) && !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data present without a read");
endmodule : string_blitter_checker

bind string_blitter string_blitter_checker u_checker (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_pixel_o(mem_pixel_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_wmask_o(mem_wmask_o), .mem_plane_we_o(mem_plane_we_o), .mem_ack_i(mem_ack_i));

// file: verification/display_memory_model.sv
module display_memory_model (
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire logic              slow_i,
    input  wire logic              mem_req_i,
    input  wire logic              mem_we_i,
    input  wire logic              mem_pixel_i,
    input  wire logic [23:0]       mem_addr_i,
    input  wire blit_pkg::planes_t mem_wdata_i,
    input  wire logic [15:0]       mem_wmask_i,
    input  wire logic [3:0]        mem_plane_we_i,
    output logic                   mem_ack_o,
    output blit_pkg::planes_t      mem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    blit_pkg::planes_t font [0:255];
    blit_pkg::planes_t pix  [logic [23:0]];
    blit_pkg::planes_t old_v;
    logic [1:0]        wait_q;

    function automatic blit_pkg::planes_t peek(input logic [23:0] a);
        return pix.exists(a) ? pix[a] : 64'h0;
    endfunction : peek

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 64'h0;
            wait_q <= 2'h0;
        end else begin
            mem_ack_o <= 1'b0;
            // Read lines toggle in every cycle except the acknowledge cycle of a read
            mem_rdata_o <= ~mem_rdata_o;
            if (mem_req_i && !mem_ack_o && wait_q < {slow_i, slow_i}) begin
                wait_q <= wait_q + 2'h1;
            end else if (mem_req_i && !mem_ack_o) begin
                wait_q <= 2'h0;
                mem_ack_o <= 1'b1;
                if (!mem_we_i) begin
                    mem_rdata_o <= mem_pixel_i ? peek(mem_addr_i) : font[mem_addr_i[7:0]];
                end else begin
                    old_v = peek(mem_addr_i);
                    for (int p = 0; p < 4; p++) begin
                        if (mem_plane_we_i[p]) begin
                            old_v[p] = (mem_wdata_i[p] & mem_wmask_i) | (old_v[p] & ~mem_wmask_i);
                        end
                    end
                    pix[mem_addr_i] = old_v;
                end
            end
        end
    end
endmodule : display_memory_model

// file: verification/font_character_string_blitter_test.sv
module font_character_string_blitter_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam blit_pkg::planes_t PAT = 64'h1234_5678_9ABC_DEF0;
    logic              clk_i, nrst_i, en_i, slow_q, reg_wr_i, reg_rd_i, mem_ack_i;
    logic              mem_req_o, mem_we_o, mem_pixel_o;
    logic [7:0]        reg_addr_i;
    logic [31:0]       reg_wdata_i, reg_rdata_o, d;
    logic [23:0]       mem_addr_o;
    logic [15:0]       mem_wmask_o;
    logic [3:0]        mem_plane_we_o;
    blit_pkg::planes_t mem_wdata_o, mem_rdata_i;
    blit_pkg::ctrl_t   c;
    int                error_cnt, checks_done;

    string_blitter DUT (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_pixel_o(mem_pixel_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .mem_wmask_o(mem_wmask_o), .mem_plane_we_o(mem_plane_we_o),
        .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));
    display_memory_model mem (.clk_i(clk_i), .nrst_i(nrst_i), .slow_i(slow_q), .mem_req_i(mem_req_o),
        .mem_we_i(mem_we_o), .mem_pixel_i(mem_pixel_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .mem_wmask_i(mem_wmask_o), .mem_plane_we_i(mem_plane_we_o), .mem_ack_o(mem_ack_i),
        .mem_rdata_o(mem_rdata_i));

    // ------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
        if (name != "") chk(name, 64'(d), 64'(exp));
    endtask : rd
    task automatic wait_flag(input int b);
        d = 32'hFFFF_FFFF;
        for (int n = 0; n < 400 && d[b] !== 1'b0; n++) rd(blit_pkg::OFS_STATUS, 32'h0, "");
        if (d[b] !== 1'b0) error_cnt++;
    endtask : wait_flag
    task automatic put_char(input int base, input int idx, input int ptr, input blit_pkg::attr_t at, input int n);
        mem.font[base + idx] = {4{16'(ptr)}};
        mem.font[base + ptr] = {4{at}};
        for (int i = 0; i < n; i++) mem.font[base + ptr + 1 + i] = PAT ^ {4{16'(i * 256)}};
    endtask : put_char
    task automatic draw(input blit_pkg::ctrl_t cc, input blit_pkg::entry_t e [4], input int n);
        wr(blit_pkg::OFS_LIST, 32'(e[0]));
        wr(blit_pkg::OFS_CTRL, {19'h0, cc, 1'b1});
        for (int i = 1; i < n; i++) begin
            wait_flag(1);
            wr(blit_pkg::OFS_LIST, 32'(e[i]));
        end
    endtask : draw
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_registers();
        rd(blit_pkg::OFS_CTRL, {19'h0, blit_pkg::CTRL_RESET, 1'b0}, "ctrl");
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0, "unmapped");
        wr(blit_pkg::OFS_RETURN, 32'hFFFF_FFFF);
        rd(blit_pkg::OFS_RETURN, 32'hFFF, "return");
        @(posedge clk_i);
        en_i <= 1'b0;
        wr(blit_pkg::OFS_RETURN, 32'h5);
        en_i <= 1'b1;
        rd(blit_pkg::OFS_RETURN, 32'hFFF, "frozen");
    endtask : s_registers
    task automatic s_left_to_right();
        put_char(16, 5, 32, '{2'h0, 4'h1, 4'h1, 6'h08}, 2);
        wr(blit_pkg::OFS_FONT0, 32'h10);
        wr(blit_pkg::OFS_PEN_X, 32'h40);
        wr(blit_pkg::OFS_PEN_Y, 32'h20);
        slow_q <= 1'b1;
        draw(blit_pkg::CTRL_RESET, '{14'h0005, 14'h0, 14'h0, 14'h0}, 1);
        wr(blit_pkg::OFS_PEN_X, 32'h7FF);
        wait_flag(0);
        slow_q <= 1'b0;
        rd(blit_pkg::OFS_PEN_X, 32'h48, "pen_x");
        rd(blit_pkg::OFS_PEN_Y, 32'h20, "pen_y");
        chk("row0", mem.peek(24'h022040), PAT & {4{16'hFF00}});
        chk("row1", mem.peek(24'h023040), (PAT ^ {4{16'h0100}}) & {4{16'hFF00}});
        chk("skipped", mem.peek(24'h021040), 64'h0);
        chk("below", mem.peek(24'h024040), 64'h0);
    endtask : s_left_to_right
    task automatic s_right_to_left();
        c = blit_pkg::CTRL_RESET;
        c.cell_scale = 1'b1;
        c.single_plane = 1'b1;
        c.font_plane = 2'h2;
        c.invert = 1'b1;
        c.combine_op = 3'h6;
        c.activity = 4'h5;
        mem.pix[24'h04307C] = {4{16'h0F0F}};
        put_char(16, 7, 64, '{2'h1, 4'h1, 4'h0, 6'h14}, 8);
        wr(blit_pkg::OFS_PEN_X, 32'h80);
        wr(blit_pkg::OFS_PEN_Y, 32'h40);
        draw(c, '{14'h0007, 14'h0, 14'h0, 14'h0}, 1);
        wait_flag(0);
        rd(blit_pkg::OFS_PEN_X, 32'h6C, "pen_x_rl");
        chk("word0", mem.peek(24'h04006C), 64'h0000_A987_0000_A987);
        chk("word7", mem.peek(24'h04307C), 64'h0F0F_AF0F_0F0F_AF0F);
        chk("right", mem.peek(24'h040080), 64'h0);
    endtask : s_right_to_left
    task automatic s_nonprinting();
        put_char(128, 1, 8, '{2'h0, 4'h0, 4'h1, 6'h0}, 0);
        put_char(16, 4, 98, '{2'h0, 4'h0, 4'h0, 6'h0}, 0);
        put_char(16, 2, 96, '{2'h0, 4'h0, 4'h2, 6'h0}, 0);
        put_char(16, 3, 97, '{2'h0, 4'h0, 4'h8, 6'h0}, 0);
        wr(blit_pkg::OFS_FONT1, 32'h80);
        wr(blit_pkg::OFS_RETURN, 32'h123);
        wr(blit_pkg::OFS_PEN_X, 32'hAA);
        wr(blit_pkg::OFS_PEN_Y, 32'hBB);
        draw(blit_pkg::CTRL_RESET, '{14'h2004, 14'h3001, 14'h2003, 14'h0}, 3);
        wait_flag(0);
        rd(blit_pkg::OFS_STATUS, 32'h0, "stopped");
        rd(blit_pkg::OFS_PEN_X, 32'h123, "ret_x");
        rd(blit_pkg::OFS_PEN_Y, 32'hBB, "keep_y");
        wr(blit_pkg::OFS_RETURN, 32'h456);
        draw(blit_pkg::CTRL_RESET, '{14'h0002, 14'h0, 14'h0, 14'h0}, 1);
        wait_flag(0);
        rd(blit_pkg::OFS_PEN_Y, 32'h456, "ret_y");
        rd(blit_pkg::OFS_PEN_X, 32'h123, "keep_x");
    endtask : s_nonprinting

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        error_cnt++;
        end_sim();
    end
    initial begin
        {error_cnt, checks_done} = '0;
        {en_i, slow_q, nrst_i, reg_wr_i, reg_rd_i} = 5'b10000;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        s_registers();
        s_left_to_right();
        s_right_to_left();
        s_nonprinting();
        end_sim();
    end
endmodule : font_character_string_blitter_test
